/* File: core/service_request_status_byte.sv */
// Status byte, service request enable and operation-complete logic
// What this block does
// - Each summary bit ANDed with its enable; any enabled bit sets bit 6.
// - Enable register loads from a write and reads back its contents.
// - Reading the enable register leaves it unchanged.
// - Writing zero to the enable register disables every summary bit.
// - Rising edge of the enabled summary raises a service request.
// - Serial poll answer carries bit 6 set in a requesting device.
// - Completing a serial poll clears the request-service function.
// - No new request until the originating event register is cleared.
// - Poll leaves master summary set until enabled summaries clear.
// - Status byte read returns master summary in bit 6 and clears nothing.
// - Bit 4 shows data waiting; clear when output buffer empty.
// - Message-available may be enabled so the controller waits.
// - Operation-complete command sets event bit 0 when operation ends.
// - Commands still accepted while operation-complete flag pending.
// - Operation-complete query never touches event bit 0.
// - Operation-complete query waits for operation end, then buffers value 1.
// - Weight 32 enables event summary; event mask 32 is command error.
// - Reading event status register clears it and re-arms requests.
// - Bits 7,5,4,2,1 carry summaries; bit 3 unused.
// - Summary bits follow sources without latching.
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "srq_status_cfg.svh"
module service_request_status_byte
  import srq_status_pkg::*;
(
  input  wire logic        hclk,        // Bus clock, 250 MHz
  input  wire logic        hresetn,     // Asynchronous reset, active low
  input  wire logic        hsel,        // Slave select
  input  wire logic [7:0]  haddr,       // Byte address
  input  wire logic [1:0]  htrans,      // Transfer type
  input  wire logic        hwrite,      // Write when high
  input  wire logic [2:0]  hsize,       // Transfer size
  input  wire logic        hready,      // Bus ready in
  input  wire logic [31:0] hwdata,      // Write data
  output logic      [31:0] hrdata,      // Read data
  output logic             hreadyout,   // Slave ready
  output logic             hresp,       // Always OKAY
  input  wire summary_s    summary_in,  // Summary levels from event sets
  input  wire logic [7:0]  std_evt_in,  // Standard event set pulses
  input  wire logic        obuf_nonempty, // Output buffer holds data
  input  wire logic        op_busy,     // Device operation in progress
  output logic             srq,         // Service request line
  output logic             opc_answer_valid, // Pulse: put answer in buffer
  output logic [7:0]       opc_answer_data   // Answer byte
);

  localparam int SREW = 8;

  logic [SREW-1:0] sre_reg;
  logic [SREW-1:0] sre_next;
  logic [7:0]      esr_reg;
  logic [7:0]      esr_next;
  logic [7:0]      ese_reg;
  logic [7:0]      ese_next;
  logic            rqs_reg;
  logic            rqs_next;
  logic            mss_prev_reg;
  logic            srq_reg;
  logic            srq_next;
  opc_state_e      opc_reg;
  opc_state_e      opc_next;
  logic            ans_reg;
  logic [31:0]     hrdata_reg;
  logic [31:0]     rd_mux;

  // Address phase captured for the data phase
  logic            dp_valid_reg;
  logic            dp_write_reg;
  logic [7:0]      dp_addr_reg;

  wire addr_phase = hsel & htrans[1] & hready;
  wire wr_now     = dp_valid_reg & dp_write_reg;
  wire rd_now     = addr_phase & ~hwrite;

  wire wr_sre     = wr_now & (dp_addr_reg == `OFS_SRE);
  wire wr_ese     = wr_now & (dp_addr_reg == `OFS_ESE);
  wire wr_evt     = wr_now & (dp_addr_reg == `OFS_EVT);
  wire wr_cmd     = wr_now & (dp_addr_reg == `OFS_CMD);
  wire rd_esr     = rd_now & (haddr == `OFS_ESR);
  wire rd_poll    = rd_now & (haddr == `OFS_POLL);
  wire [1:0] cmd  = hwdata[1:0];

  // Standard event summary is the masked event register
  wire esb        = |(esr_reg & ese_reg);
  logic [7:0] stb_sum;
  assign stb_sum[`BIT_OPER]  = summary_in.oper;
  assign stb_sum[`BIT_RQS]   = 1'b0;
  assign stb_sum[`BIT_ESB]   = esb;
  assign stb_sum[`BIT_MAV]   = obuf_nonempty;
  assign stb_sum[`BIT_UNUSED] = 1'b0;
  assign stb_sum[`BIT_HWERR] = summary_in.hwerr;
  assign stb_sum[`BIT_OPERR] = summary_in.operr;
  assign stb_sum[`BIT_OPC]   = 1'b0;

  // Master summary follows the masked summaries directly
  wire mss       = |(stb_sum & sre_reg & `SUM_MASK);
  wire mss_rise  = mss & ~mss_prev_reg;

  wire [7:0] stb_query = stb_sum | ({7'h00, mss} << `BIT_RQS);
  wire [7:0] stb_poll  = stb_sum | ({7'h00, rqs_reg} << `BIT_RQS);

  // Request-service: a new rise wins over a poll in the same cycle
  assign rqs_next = mss_rise ? 1'b1 : (rd_poll ? 1'b0 : rqs_reg);
  assign srq_next = rqs_next;
  assign sre_next = wr_sre ? hwdata[SREW-1:0] : sre_reg;

  // Event register: sources set, reading clears; a set wins the clear
  wire [7:0] esr_set;
  assign esr_set = std_evt_in
                 | ({7'h00, (opc_reg == OPC_FLAG) & ~op_busy}
                    << `BIT_OPC)
                 | (wr_evt ? hwdata[7:0] : 8'h00);
  assign esr_next = (rd_esr ? 8'h00 : esr_reg) | esr_set;
  assign ese_next = wr_ese ? hwdata[7:0] : ese_reg;

  // Operation-complete sequencing
  always_comb begin
    opc_next = opc_reg;
    unique case (opc_reg)
      OPC_IDLE: begin
        if (wr_cmd && cmd == `CMD_OPC) begin
          opc_next = OPC_FLAG;
        end else if (wr_cmd && cmd == `CMD_OPCQ) begin
          opc_next = OPC_HOLD;
        end
      end
      OPC_FLAG: begin
        if (wr_cmd && cmd == `CMD_OPCQ) begin
          opc_next = OPC_HOLD;
        end else if (wr_cmd && cmd == `CMD_RST) begin
          opc_next = OPC_IDLE;
        end else if (!op_busy) begin
          opc_next = OPC_IDLE;
        end
      end
      OPC_HOLD: begin
        if (!op_busy || (wr_cmd && cmd == `CMD_RST)) begin
          opc_next = OPC_IDLE;
        end
      end
      default: opc_next = OPC_IDLE;
    endcase
  end

  // Query completion does not touch event bit 0
  wire opc_done_q = (opc_reg == OPC_HOLD) & ~op_busy;

  // Read mux; unmapped reads as zero
  wire hit_sre  = haddr == `OFS_SRE;
  wire hit_stb  = haddr == `OFS_STB;
  wire hit_esr  = haddr == `OFS_ESR;
  wire hit_ese  = haddr == `OFS_ESE;
  wire hit_op   = haddr == `OFS_OPSTAT;
  assign rd_mux = hit_sre  ? {24'h000000, sre_reg}   :
                  hit_stb  ? {24'h000000, stb_query} :
                  rd_poll  ? {24'h000000, stb_poll}  :
                  hit_esr  ? {24'h000000, esr_reg}   :
                  hit_ese  ? {24'h000000, ese_reg}   :
                  hit_op   ? {30'h00000000, opc_reg} :
                  32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
      hrdata_reg   <= 32'h00000000;
    end else begin
      dp_valid_reg <= addr_phase;
      dp_write_reg <= hwrite;
      dp_addr_reg  <= haddr;
      if (rd_now) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sre_reg      <= `SRE_RESET;
      esr_reg      <= 8'h00;
      ese_reg      <= `ESE_RESET;
      rqs_reg      <= 1'b0;
      mss_prev_reg <= 1'b0;
      srq_reg      <= 1'b0;
      opc_reg      <= OPC_IDLE;
      ans_reg      <= 1'b0;
    end else begin
      sre_reg      <= sre_next;
      esr_reg      <= esr_next;
      ese_reg      <= ese_next;
      rqs_reg      <= rqs_next;
      mss_prev_reg <= mss;
      srq_reg      <= srq_next;
      opc_reg      <= opc_next;
      ans_reg      <= opc_done_q;
    end
  end

  assign hrdata           = hrdata_reg;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign srq              = srq_reg;
  assign opc_answer_valid = ans_reg;
  assign opc_answer_data  = `OPC_ANSWER;

endmodule

/* File: core/srq_status_cfg.svh */
// Register offsets, field positions and reset values for the status byte block
`ifndef SRQ_STATUS_CFG_SVH
`define SRQ_STATUS_CFG_SVH
`define OFS_SRE        8'h00
`define OFS_STB        8'h04
`define OFS_POLL       8'h08
`define OFS_ESR        8'h0c
`define OFS_ESE        8'h10
`define OFS_EVT        8'h14
`define OFS_CMD        8'h18
`define OFS_OBUF       8'h1c
`define OFS_OPSTAT     8'h20
`define BIT_OPER       7
`define BIT_RQS        6
`define BIT_ESB        5
`define BIT_MAV        4
`define BIT_UNUSED     3
`define BIT_HWERR      2
`define BIT_OPERR      1
`define BIT_OPC        0
`define SUM_MASK       8'hb6
`define SRE_RESET      8'h00
`define ESE_RESET      8'h00
`define OPC_ANSWER     8'h31
`define CMD_OPC        2'h1
`define CMD_OPCQ       2'h2
`define CMD_RST        2'h3
`endif

/* File: core/srq_status_pkg.sv */
// Types shared by the status byte block
package srq_status_pkg;
  typedef enum logic [1:0] {
    OPC_IDLE = 2'b00,
    OPC_FLAG = 2'b01,
    OPC_HOLD = 2'b10
  } opc_state_e;
  typedef struct packed {
    logic oper;
    logic hwerr;
    logic operr;
  } summary_s;
endpackage

/* File: dv/ctrl_buf_model.sv */
// Controller-side output buffer fed by query answers
`timescale 1ns/1ps
module ctrl_buf_model (
  input  wire logic       hclk,     // Clock
  input  wire logic       hresetn,  // Reset, active low
  input  wire logic       load,     // Answer strobe
  input  wire logic [7:0] din,      // Answer byte
  input  wire logic       pop,      // Controller takes the byte
  output logic            nonempty, // Byte waiting
  output logic [7:0]      dout      // Byte held
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nonempty <= 1'b0;
      dout     <= 8'h00;
    end else if (load) begin
      nonempty <= 1'b1;
      dout     <= din;
    end else if (pop) begin
      nonempty <= 1'b0;
      dout     <= ~dout; // A taken byte must not look still valid
    end
  end
endmodule

/* File: dv/srq_status_chk.sv */
// Port checker for the status byte block
`timescale 1ns/1ps
`include "srq_status_cfg.svh"
module srq_status_chk
  import srq_status_pkg::*;
(
  input wire logic        hclk,             // Clock
  input wire logic        hresetn,          // Reset, active low
  input wire logic        hsel,             // Select
  input wire logic [7:0]  haddr,            // Address
  input wire logic [1:0]  htrans,           // Transfer type
  input wire logic        hwrite,           // Write
  input wire logic        hready,           // Ready in
  input wire logic [31:0] hrdata,           // Read data
  input wire logic        hreadyout,        // Ready out
  input wire logic        hresp,            // Response
  input wire summary_s    summary_in,       // Summary levels
  input wire logic        obuf_nonempty,    // Buffer level
  input wire logic        srq,              // Request line
  input wire logic        opc_answer_valid, // Answer strobe
  input wire logic [7:0]  opc_answer_data   // Answer byte
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire rd      = hsel && htrans[1] && hready && !hwrite;
  wire stb_rd  = rd && haddr == `OFS_STB;
  wire poll_rd = rd && haddr == `OFS_POLL;
  property p_rdy;
    hreadyout;
  endproperty
  a_rdy: assert property (p_rdy) else $error("slave not ready");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_ans;
    opc_answer_valid |-> opc_answer_data == 8'h31 ##1 !opc_answer_valid;
  endproperty
  a_ans: assert property (p_ans) else $error("bad answer");
  property p_hold;
    srq && !poll_rd |=> srq;
  endproperty
  a_hold: assert property (p_hold) else $error("srq dropped");
  property p_stb;
    stb_rd |=> hrdata[31:8] == 24'h0 && hrdata[3] == 1'b0;
  endproperty
  a_stb: assert property (p_stb) else $error("unused bits set");
  property p_mav;
    stb_rd |=> hrdata[4] == $past(obuf_nonempty);
  endproperty
  a_mav: assert property (p_mav) else $error("mav wrong");
  property p_sum;
    stb_rd |=> hrdata[7] == $past(summary_in.oper)
      && hrdata[2] == $past(summary_in.hwerr)
      && hrdata[1] == $past(summary_in.operr);
  endproperty
  a_sum: assert property (p_sum) else $error("summary wrong");
  property p_poll;
    poll_rd && srq |=> hrdata[6];
  endproperty
  a_poll: assert property (p_poll) else $error("poll bit6 low");
endmodule
bind service_request_status_byte srq_status_chk u_chk (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .summary_in, .obuf_nonempty, .srq, .opc_answer_valid, .opc_answer_data);

/* File: dv/tb_top.sv */
// Self-checking bench for the status byte block
`timescale 1ns/1ps
`include "srq_status_cfg.svh"
module tb_top;
  import srq_status_pkg::*;
  logic        hclk, hresetn, hwrite, op_busy, pop;
  logic [7:0]  haddr, std_evt_in, dout;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, seed, r, d32;
  summary_s    summary_in;
  wire         hreadyout, hresp, srq, opc_answer_valid, obuf_nonempty;
  wire [7:0]   opc_answer_data;
  int          miscompares, checks, i;
  service_request_status_byte DUT (.hclk, .hresetn, .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .summary_in, .std_evt_in, .obuf_nonempty,
    .op_busy, .srq, .opc_answer_valid, .opc_answer_data);
  ctrl_buf_model PEER (.hclk, .hresetn, .load(opc_answer_valid),
    .din(opc_answer_data), .pop, .nonempty(obuf_nonempty), .dout);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] stb_exp(summary_s s, logic [7:0] e);
    logic [7:0] b;
    b = {s.oper, 3'h0, 1'b0, s.hwerr, s.operr, 1'b0};
    b[6] = |(b & e & 8'hb6);
    return {24'h0, b};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    d32 = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(d32, e);
  endtask
  task automatic evt_tick(input logic [7:0] ev, input int n);
    std_evt_in <= ev;
    @(posedge hclk);
    std_evt_in <= 8'h00;
    repeat (n) @(posedge hclk);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    seed = 32'd57; hresetn = 1'b0; haddr = 8'h00; htrans = 2'h0;
    hwrite = 1'b0; hwdata = 32'h0; summary_in = '0; std_evt_in = 8'h00;
    op_busy = 1'b0; pop = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(`OFS_SRE, 32'h0);
    rc(8'h3c, 32'h0);
    for (i = 0; i < 40; i++) begin
      r = (i == 0) ? 32'h7ff : rnd();
      xfer(1'b1, `OFS_SRE, {24'h0, r[7:0]});
      summary_in <= r[10:8];
      rc(`OFS_SRE, {24'h0, r[7:0]});
      rc(`OFS_STB, stb_exp(r[10:8], r[7:0]));
      rc(`OFS_STB, stb_exp(r[10:8], r[7:0]));
    end
    xfer(1'b1, `OFS_SRE, 32'h0);
    rc(`OFS_SRE, 32'h0);
    rc(`OFS_STB, stb_exp(r[10:8], 8'h00));
    $display("enable and summary test done");
    summary_in <= '0;
    xfer(1'b1, `OFS_SRE, 32'h20);
    xfer(1'b1, `OFS_ESE, 32'h20);
    xfer(1'b0, `OFS_POLL, 32'h0);
    evt_tick(8'h20, 3);
    chk(srq, 1);
    rc(`OFS_POLL, 32'h60);
    evt_tick(8'h00, 2);
    chk(srq, 0);
    rc(`OFS_STB, 32'h60);
    evt_tick(8'h20, 3);
    chk(srq, 0);
    rc(`OFS_ESR, 32'h20);
    rc(`OFS_STB, 32'h0);
    evt_tick(8'h20, 3);
    chk(srq, 1);
    rc(`OFS_POLL, 32'h60);
    rc(`OFS_ESR, 32'h20);
    $display("service request test done");
    op_busy <= 1'b1;
    xfer(1'b1, `OFS_CMD, {30'h0, `CMD_OPC});
    rc(`OFS_SRE, 32'h20);
    rc(`OFS_ESR, 32'h0);
    op_busy <= 1'b0;
    evt_tick(8'h00, 3);
    rc(`OFS_ESR, 32'h1);
    xfer(1'b1, `OFS_SRE, 32'h10);
    op_busy <= 1'b1;
    xfer(1'b1, `OFS_CMD, {30'h0, `CMD_OPCQ});
    evt_tick(8'h00, 5);
    chk(obuf_nonempty, 0);
    op_busy <= 1'b0;
    i = 0;
    while (!opc_answer_valid && i < 50) begin
      @(negedge hclk);
      i++;
    end
    chk(opc_answer_valid, 1);
    chk(opc_answer_data, 32'h31);
    // Back onto the rising edge before any bus task runs again
    @(posedge hclk);
    evt_tick(8'h00, 3);
    chk(srq, 1);
    chk(dout, 32'h31);
    rc(`OFS_STB, 32'h50);
    rc(`OFS_ESR, 32'h0);
    pop <= 1'b1;
    @(posedge hclk);
    pop <= 1'b0;
    evt_tick(8'h00, 1);
    rc(`OFS_STB, 32'h0);
    xfer(1'b1, `OFS_EVT, 32'h20);
    rc(`OFS_ESR, 32'h20);
    rc(`OFS_ESE, 32'h20);
    op_busy <= 1'b1;
    xfer(1'b1, `OFS_CMD, {30'h0, `CMD_OPCQ});
    rc(`OFS_OPSTAT, {30'h0, OPC_HOLD});
    xfer(1'b1, `OFS_CMD, {30'h0, `CMD_RST});
    rc(`OFS_OPSTAT, {30'h0, OPC_IDLE});
    op_busy <= 1'b0;
    evt_tick(8'h00, 3);
    chk(obuf_nonempty, 0);
    $display("operation complete test done");
    // Reset in mid-run while the request line is still up
    hresetn <= 1'b0;
    @(posedge hclk);
    chk(srq, 0);
    chk(opc_answer_valid, 0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(`OFS_SRE, 32'h0);
    rc(`OFS_STB, 32'h0);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
